// ===== rtl/path_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module path_fsm
   import path_pkg::*;
#(
   parameter int LANES = 2
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // path signals
   path_if.fsm p
);
   path_state_t state_reg, state_next;
   logic [7:0] cnt_reg;
   logic pend_reg;
   logic [LANES-1:0] quiet_reg;
   logic changed_reg;
   wire cnt_done = (cnt_reg == 8'h00);
   // pending reinit trigger also stops the path
   wire stop_now = p.stop_cond || pend_reg;
   wire [LANES-1:0] lane_mute = p.off | p.mute;
   wire enter = (state_next != state_reg);
   wire flag_ok = (state_next == ST_READY_IDLE) || (state_next == ST_RUNNING) || (state_next == ST_INACTIVE);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUNNING: if (stop_now) state_next = ST_TURNING_OFF;
         ST_TURNING_OFF: if (cnt_done) state_next = ST_READY_IDLE;
         ST_READY_IDLE: begin
            if (pend_reg) state_next = ST_TEARDOWN;
            else if (!stop_now) state_next = ST_TURNING_ON;
         end
         ST_TEARDOWN: if (cnt_done) state_next = ST_INACTIVE;
         ST_INACTIVE: if (pend_reg) state_next = ST_BRINGUP;
         ST_BRINGUP: if (cnt_done) state_next = ST_READY_IDLE;
         ST_TURNING_ON: begin
            if (stop_now) state_next = ST_TURNING_OFF;
            else if (cnt_done) state_next = ST_RUNNING;
         end
         default: state_next = ST_INACTIVE;
      endcase
   end
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state_reg <= path_state_t'(RESET_STATE);
         cnt_reg <= 8'h00;
         pend_reg <= 1'b0;
         changed_reg <= 1'b0;
         quiet_reg <= '1;
      end else begin
         state_reg <= state_next;
         changed_reg <= enter && flag_ok;
         if (enter && state_next == ST_TURNING_OFF) cnt_reg <= 8'(SETTLE_CYCLES);
         else if (enter) cnt_reg <= 8'(TASK_CYCLES);
         else if (!cnt_done) cnt_reg <= cnt_reg - 8'h01;
         if (p.trigger) pend_reg <= 1'b1;
         else if (state_reg == ST_BRINGUP) pend_reg <= 1'b0;
         case (state_reg)
            ST_RUNNING: quiet_reg <= p.los;
            ST_TURNING_OFF, ST_READY_IDLE: quiet_reg <= lane_mute | p.los;
            ST_TURNING_ON: quiet_reg <= p.los;
            default: quiet_reg <= '1;
         endcase
      end
   end
   assign p.state = state_reg;
   assign p.tx_quiet = quiet_reg;
   assign p.changed = changed_reg;
   a_stop_exit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      state_reg == ST_RUNNING && p.stop_cond |=> state_reg == ST_TURNING_OFF) else $error("running ignored stop");
   a_reinit_stop: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      state_reg == ST_RUNNING && pend_reg |=> state_reg == ST_TURNING_OFF) else $error("reinit did not stop path");
   a_settle_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      state_reg == ST_TURNING_OFF && !cnt_done |=> state_reg == ST_TURNING_OFF) else $error("turning off left early");
   a_flag_allowed: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      changed_reg |-> (state_reg == ST_READY_IDLE || state_reg == ST_RUNNING || state_reg == ST_INACTIVE))
      else $error("changed flag in wrong state");
   a_los_mute: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (p.los != '0) |=> ((p.tx_quiet & $past(p.los)) == $past(p.los))) else $error("los lane not muted");
   a_ready_teardown: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      state_reg == ST_READY_IDLE && pend_reg |=> state_reg == ST_TEARDOWN) else $error("ready skipped teardown");
endmodule : path_fsm
`default_nettype wire

// ===== rtl/path_if.sv
`timescale 1ns/1ps
`default_nettype none
interface path_if #(parameter int LANES = 2);
   logic trigger;
   logic stop_cond;
   logic [LANES-1:0] off;
   logic [LANES-1:0] mute;
   logic [LANES-1:0] los;
   logic [LANES-1:0] tx_quiet;
   logic [3:0] state;
   logic changed;
   modport fsm (input trigger, stop_cond, off, mute, los, output tx_quiet, state, changed);
   modport top (output trigger, stop_cond, off, mute, los, input tx_quiet, state, changed);
endinterface : path_if
`default_nettype wire

// ===== rtl/path_pkg.sv
// What this block does
// - reinit trigger raises path stop condition
// - one write may reinit several paths
// - unselected paths keep state and traffic
// - output off or forced mute stops path
// - turning-off is transient, applies mute actions
// - turning-off entry updates lane state field
// - each lane muted per own controls
// - leave turning-off when SETTLE_CYCLES settle count expires
// - tx loss of signal mutes lane
// - reinit walks full teardown and bringup loop
// - raised flag interrupts unless masked
// - no flag set where not applicable
// - restrictions only on implemented flags
// - running goes turning-off on stop condition
// - ready-idle: teardown first, else turning-on
// - ready-idle entry updates state, sets changed flag
package path_pkg;
   // -----------------------------
   // path states, 4-bit field codes
   // -----------------------------
   typedef enum logic [3:0] {
      ST_INACTIVE = 4'h1,
      ST_BRINGUP = 4'h2,
      ST_TEARDOWN = 4'h3,
      ST_READY_IDLE = 4'h4,
      ST_RUNNING = 4'h5,
      ST_TURNING_OFF = 4'h6,
      ST_TURNING_ON = 4'h7
   } path_state_t;
   localparam logic [3:0] RESET_STATE = 4'h1;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TASK_CYCLES = 8;
endpackage : path_pkg

// ===== rtl/path_turnoff_top.sv
`timescale 1ns/1ps
`default_nettype none
module path_turnoff_top
   import path_pkg::*;
#(
   parameter int PATHS = 2,
   parameter int LANES = 2
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // host write strobe and controls
   input wire logic write_done_in,
   input wire logic [PATHS*LANES-1:0] lane_reinit_trigger_in,
   input wire logic [PATHS*LANES-1:0] tx_lane_output_off_in,
   input wire logic [PATHS*LANES-1:0] tx_lane_forced_mute_in,
   input wire logic [PATHS*LANES-1:0] flag_mask_in,
   // lane status
   input wire logic [PATHS*LANES-1:0] tx_los_in,
   // outputs
   output logic [PATHS*LANES-1:0] tx_quiet_out,
   output logic [PATHS*LANES*4-1:0] lane_state_out,
   output logic [PATHS*LANES-1:0] state_changed_flag_out,
   output logic irq_out
);
   logic [PATHS*LANES-1:0] off_reg, mute_reg, flag_reg;
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         off_reg <= '0;
         mute_reg <= '0;
      end else if (write_done_in) begin
         off_reg <= tx_lane_output_off_in;
         mute_reg <= tx_lane_forced_mute_in;
      end
   end
   genvar g, l;
   generate
      for (g = 0; g < PATHS; g++) begin : gp
         path_if #(.LANES(LANES)) pi ();
         wire [LANES-1:0] trig = lane_reinit_trigger_in[g*LANES +: LANES];
         assign pi.trigger = write_done_in && (|trig);
         assign pi.off = off_reg[g*LANES +: LANES];
         assign pi.mute = mute_reg[g*LANES +: LANES];
         assign pi.los = tx_los_in[g*LANES +: LANES];
         // stop on any off or mute
         assign pi.stop_cond = (|pi.off) || (|pi.mute);
         path_fsm #(.LANES(LANES)) u_fsm (
            .sys_clk_in(sys_clk_in),
            .resetn_in(resetn_in),
            .p(pi)
         );
         assign tx_quiet_out[g*LANES +: LANES] = pi.tx_quiet;
         for (l = 0; l < LANES; l++) begin : gl
            assign lane_state_out[(g*LANES+l)*4 +: 4] = pi.state;
            always_ff @(posedge sys_clk_in) begin
               if (!resetn_in) flag_reg[g*LANES+l] <= 1'b0;
               else if (pi.changed) flag_reg[g*LANES+l] <= 1'b1;
               else if (write_done_in && lane_reinit_trigger_in[g*LANES+l]) flag_reg[g*LANES+l] <= 1'b0;
            end
         end
      end
   endgenerate
   assign state_changed_flag_out = flag_reg;
   assign irq_out = |(flag_reg & ~flag_mask_in);
   a_irq_mask: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      |(flag_reg & ~flag_mask_in) |-> irq_out) else $error("irq missing");
endmodule : path_turnoff_top
`default_nettype wire

// ===== testbench/data_path_turnoff_reinit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, e); end end
module data_path_turnoff_reinit_bench;
   import path_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, wr, irq;
   logic [3:0] trig, off, mute, quiet, flags, mask = 4'h0, los = 4'h0;
   logic [15:0] states;
   int bad_count = 0, n_checks = 0;
   path_turnoff_top dut (.sys_clk_in(clk), .resetn_in(resetn), .write_done_in(wr), .lane_reinit_trigger_in(trig),
      .tx_lane_output_off_in(off), .tx_lane_forced_mute_in(mute), .flag_mask_in(mask), .tx_los_in(los),
      .tx_quiet_out(quiet), .lane_state_out(states), .state_changed_flag_out(flags), .irq_out(irq));
   host_model h (.clk_in(clk), .wr_out(wr), .trig_out(trig), .off_out(off), .mute_out(mute));
   initial forever #25 clk = ~clk;
   function automatic logic [3:0] st(input int l);
      return states[l*4 +: 4];
   endfunction : st
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic wait_st(input int l, input logic [3:0] c);
      int i;
      for (i = 0; i < 400 && st(l) !== c; i++) @(negedge clk);
      `CHK(st(l), c)
      if (st(l) !== c) stop_test();
   endtask : wait_st
   task automatic t_bringup();
      h.xfer(4'hF, 4'h0, 4'h0);
      wait_st(0, 4'h5);
      wait_st(2, 4'h5);
      `CHK(flags, 4'hF)
      `CHK(irq, 1'b1)
      mask = 4'hF;
      los = 4'h2;
      repeat (2) @(negedge clk);
      `CHK(irq, 1'b0)
      `CHK(quiet, 4'h2)
      los = 4'h0;
      $display("bringup done");
   endtask : t_bringup
   task automatic t_stop(input int l, input logic [3:0] o, m);
      h.xfer(4'h0, o, m);
      repeat (10) @(negedge clk);
      `CHK(st(l), 4'h6)
      `CHK(st(l ^ 1), 4'h6)
      `CHK(st(l ^ 2), 4'h5)
      wait_st(l, 4'h4);
      `CHK(quiet, o | m)
      h.xfer(4'h0, 4'h0, 4'h0);
      wait_st(l, 4'h5);
      $display("stop done");
   endtask : t_stop
   task automatic t_reinit();
      logic [35:0] seq;
      int i;
      seq = 36'h5;
      h.xfer(4'hC, 4'h0, 4'h0);
      for (i = 0; i < 400 && seq[35:32] !== 4'h5; i++) begin
         @(negedge clk);
         if (st(2) !== seq[3:0]) seq = {seq[31:0], st(2)};
      end
      `CHK(seq, 36'h564312475)
      `CHK(st(0), 4'h5)
      $display("reinit done");
   endtask : t_reinit
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      t_bringup();
      t_stop(0, 4'h1, 4'h0);
      t_stop(3, 4'h0, 4'h8);
      t_reinit();
      stop_test();
   end
endmodule : data_path_turnoff_reinit_bench
`default_nettype wire

// ===== testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model #(parameter int N = 4) (
   input wire logic clk_in,
   output logic wr_out = 1'b0,
   output logic [N-1:0] trig_out = '0,
   output logic [N-1:0] off_out = '0,
   output logic [N-1:0] mute_out = '0
);
   task automatic xfer(input logic [N-1:0] t, o, m);
      @(negedge clk_in);
      trig_out = t;
      off_out = o;
      mute_out = m;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
   endtask : xfer
endmodule : host_model
`default_nettype wire
